// file: eeac_pkg.sv
// Constants, types and state codes for the emulated EEPROM control block.
// Assumes a 10 MHz system clock; all times below are turned into cycles.
package eeac_pkg;
   // Address windows
   localparam logic [31:0] WIN_BASE  = 32'h1400_0000;
   localparam logic [31:0] WIN_TOP   = 32'h17FF_FFFF;
   localparam logic [31:0] PF_TOP    = 32'h0FFF_FFFF;
   // Timing, in nanoseconds, then in cycles
   localparam int          CLK_PERIOD_NS = 100;
   localparam int          T_ERPG_NS     = 1500000;
   localparam int          T_PROG_NS     = 100000;
   localparam int          ERPG_CYC      = T_ERPG_NS / CLK_PERIOD_NS;
   localparam int          PROG_CYC      = T_PROG_NS / CLK_PERIOD_NS;
   // Sizes and encodings
   localparam int          MIN_SIZE_HW   = 16;
   localparam logic [3:0]  SIZE_MAX_CODE = 4'h7;
   localparam logic [15:0] ERASED_HW     = 16'hFFFF;
   localparam logic [1:0]  SZ_BYTE       = 2'h0;
   localparam logic [1:0]  SZ_HALF       = 2'h1;
   localparam logic [1:0]  SZ_WORD       = 2'h2;

   typedef struct packed {
      logic [3:0] size;
      logic [3:0] split;
      logic [3:0] part;
   } eeac_cfg_s;

   typedef enum logic [5:0] {
      ST_CFG  = 6'h01,
      ST_LOAD = 6'h02,
      ST_IDLE = 6'h04,
      ST_PGM  = 6'h08,
      ST_WAIT = 6'h10,
      ST_PART = 6'h20
   } eeac_state_e;
endpackage

// file: eeac_nv_if.sv
// Link between the controller and its backup flash store.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface eeac_nv_if #(
   parameter int AW = 11
);
   logic                 wr_en;
   logic                 commit_en;
   logic                 erase_all;
   logic                 cfg_wr;
   logic [AW-1:0]        waddr;
   logic [AW-1:0]        raddr;
   logic [15:0]          wdata;
   logic [15:0]          rdata;
   logic [15:0]          rprev;
   logic                 rvalid;
   logic                 rcommit;
   eeac_pkg::eeac_cfg_s  cfg_wdata;
   eeac_pkg::eeac_cfg_s  cfg;
   logic                 cfg_valid;

   modport ctl (output wr_en, commit_en, erase_all, cfg_wr, waddr, raddr,
                output wdata, cfg_wdata,
                input  rdata, rprev, rvalid, rcommit, cfg, cfg_valid);
   modport mem (input  wr_en, commit_en, erase_all, cfg_wr, waddr, raddr,
                input  wdata, cfg_wdata,
                output rdata, rprev, rvalid, rcommit, cfg, cfg_valid);
endinterface
`default_nettype wire

// file: eeac_nvm.sv
// Backup flash store: one record slot per emulated halfword plus config.
// Assumes nonvolatile contents: nothing here is touched by system reset.
`timescale 1ns/1ps
`default_nettype none
module eeac_nvm #(
   parameter int DEPTH = 2048,
   parameter int AW    = 11
) (
   input  wire logic i_clk_sys,
   eeac_nv_if.mem    nv
);
   typedef struct packed {
      logic [DEPTH-1:0]    valid;
      logic [DEPTH-1:0]    commit;
      eeac_pkg::eeac_cfg_s cfg;
      logic                cfg_valid;
   } eeac_nvm_s;

   eeac_nvm_s   q;
   eeac_nvm_s   d;
   logic [15:0] data_mem [0:DEPTH-1];
   logic [15:0] prev_mem [0:DEPTH-1];

   // Record lookup
   assign nv.rdata     = data_mem[nv.raddr];
   assign nv.rprev     = prev_mem[nv.raddr];
   assign nv.rvalid    = q.valid[nv.raddr];
   assign nv.rcommit   = q.commit[nv.raddr];
   assign nv.cfg       = q.cfg;
   assign nv.cfg_valid = q.cfg_valid;

   // Record bookkeeping; a record is only trusted once committed
   always_comb begin
      d = q;
      if (nv.erase_all) begin
         d.valid     = '0;
         d.commit    = '0;
         d.cfg_valid = 1'b0;
      end else begin
         if (nv.cfg_wr) begin
            d.cfg       = nv.cfg_wdata;
            d.cfg_valid = 1'b1;
         end
         if (nv.wr_en) begin
            d.valid[nv.waddr]  = 1'b1;
            d.commit[nv.waddr] = 1'b0;
         end
         if (nv.commit_en) begin
            d.commit[nv.waddr] = 1'b1;
         end
      end
   end

   // No reset: this models flash, which keeps state across resets
   always_ff @(posedge i_clk_sys) begin
      q <= d;
      if (nv.wr_en && !nv.erase_all) begin
         // Keep last good value so a torn record can fall back to it
         if (!q.valid[nv.waddr]) begin
            prev_mem[nv.waddr] <= eeac_pkg::ERASED_HW;
         end else if (q.commit[nv.waddr]) begin
            prev_mem[nv.waddr] <= data_mem[nv.waddr];
         end
         data_mem[nv.waddr] <= nv.wdata;
      end
   end
endmodule
`default_nettype wire

// file: eeac_top.sv
// Emulated EEPROM controller: RAM window backed by a record flash store.
// Assumes a single bus master on i_clk_sys issuing one-cycle requests.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Partition command stores three config values
// - Mass erase clears config and records
// - Config reloads automatically after every reset
// - Boot rebuilds RAM image from records
// - Ready flag low until boot load done
// - Access beyond configured size gives error
// - Byte, halfword, word reads and writes
// - Each record holds one full halfword
// - Window writes program flash record when emulation enabled
// - Program flash reads unaffected by programming
// - Reads come from RAM, no flash work
// - Erase plus program within 1.5 ms
// - Writing all ones pre-erases location
// - Command complete can raise interrupt
// - Pre-erased location programs in ~100 us
// - Torn records fall back to last good
module eeac_top #(
   parameter int DEPTH       = 2048,
   parameter int AW          = 11,
   parameter int ERPG_CYCLES = eeac_pkg::ERPG_CYC,
   parameter int PROG_CYCLES = eeac_pkg::PROG_CYC
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rstn,
   input  wire logic        i_bus_req,
   input  wire logic        i_bus_we,
   input  wire logic [1:0]  i_bus_size,
   input  wire logic [31:0] i_bus_addr,
   input  wire logic [31:0] i_bus_wdata,
   output logic             o_bus_ack,
   output logic             o_bus_err,
   output logic [31:0]      o_bus_rdata,
   output logic             o_pf_sel,
   input  wire logic        i_part_req,
   input  wire logic [3:0]  i_part_size,
   input  wire logic [3:0]  i_part_split,
   input  wire logic [3:0]  i_part_flash,
   input  wire logic        i_mass_erase,
   input  wire logic        i_cc_irq_en,
   output logic             o_emulation_ready_flag,
   output logic             o_command_complete_flag,
   output logic             o_cc_irq,
   output logic             o_emu_enabled,
   output logic             o_compromised,
   output logic [11:0]      o_cfg
);
   localparam int TW = $clog2(ERPG_CYCLES + 1);

   typedef struct packed {
      eeac_pkg::eeac_state_e st;
      logic [AW-1:0]         idx;
      logic [TW-1:0]         timer;
      logic [AW-1:0]         wbase;
      logic [1:0]            hwmask;
      logic                  slot;
      eeac_pkg::eeac_cfg_s   cfg;
      logic                  enabled;
      logic                  ready;
      logic                  command_complete_flag;
      logic                  compromised;
      logic                  ack;
      logic                  err;
      logic [31:0]           rdata;
   } eeac_top_s;

   eeac_top_s     q;
   eeac_top_s     d;
   logic [15:0]   ram [0:DEPTH-1];
   eeac_nv_if #(.AW(AW)) nv ();

   // Byte lanes touched by an access
   function automatic logic [3:0] lanes(input logic [1:0] sz,
                                        input logic [1:0] a);
      logic [3:0] be;
      be = 4'h0;
      case (sz)
         eeac_pkg::SZ_BYTE: be = 4'h1 << a;
         eeac_pkg::SZ_HALF: be = a[1] ? 4'hC : 4'h3;
         default:           be = 4'hF;
      endcase
      return be;
   endfunction

   // Emulated size in halfwords from the size code
   function automatic logic [AW:0] size_hw(input logic [3:0] code);
      return (AW+1)'(eeac_pkg::MIN_SIZE_HW) << code;
   endfunction

   eeac_nvm #(
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_nvm (
      .i_clk_sys (i_clk_sys),
      .nv        (nv)
   );

   // Address decode of the emulation window
   logic [31:0]   off;
   logic          in_win;
   logic          in_range;
   logic [AW-1:0] wbase;
   logic [3:0]    be;
   logic [AW+1:0] lim_bytes;
   logic          bus_wr;
   logic          load_we;
   logic [15:0]   load_data;

   assign off       = i_bus_addr - eeac_pkg::WIN_BASE;
   assign in_win    = (i_bus_addr >= eeac_pkg::WIN_BASE) &&
                      (i_bus_addr <= eeac_pkg::WIN_TOP);
   assign lim_bytes = q.enabled ? {size_hw(q.cfg.size), 1'b0}
                                : (AW+2)'(2 * DEPTH);
   assign in_range  = in_win && (off < 32'(lim_bytes));
   assign wbase     = {off[AW:2], 1'b0};
   assign be        = lanes(i_bus_size, i_bus_addr[1:0]);
   // Program flash reads are never held off by programming
   assign o_pf_sel  = i_bus_req && (i_bus_addr <= eeac_pkg::PF_TOP);

   // Torn record reads back as its last good value
   assign load_data = !nv.rvalid ? eeac_pkg::ERASED_HW :
                      (nv.rcommit ? nv.rdata : nv.rprev);

   // Controller
   always_comb begin
      d            = q;
      d.ack        = 1'b0;
      d.err        = 1'b0;
      bus_wr       = 1'b0;
      load_we      = 1'b0;
      nv.wr_en     = 1'b0;
      nv.commit_en = 1'b0;
      nv.erase_all = 1'b0;
      nv.cfg_wr    = 1'b0;
      nv.waddr     = q.wbase + AW'(q.slot);
      nv.raddr     = q.idx;
      nv.wdata     = ram[q.wbase + AW'(q.slot)];
      nv.cfg_wdata = '{size: i_part_size, split: i_part_split,
                       part: i_part_flash};
      // Window touched while flash busy or loading: refused
      if (i_bus_req && in_win && q.st != eeac_pkg::ST_IDLE) begin
         d.err = 1'b1;
      end
      case (q.st)
         eeac_pkg::ST_CFG: begin
            d.cfg     = nv.cfg;
            d.enabled = nv.cfg_valid &&
                        (nv.cfg.size <= eeac_pkg::SIZE_MAX_CODE);
            d.idx     = '0;
            if (d.enabled) begin
               d.st = eeac_pkg::ST_LOAD;
            end else begin
               d.st   = eeac_pkg::ST_IDLE;
               d.command_complete_flag = 1'b1;
            end
         end
         eeac_pkg::ST_LOAD: begin
            load_we = 1'b1;
            if (nv.rvalid && !nv.rcommit) begin
               d.compromised = 1'b1;
            end
            if ({1'b0, q.idx} == size_hw(q.cfg.size) - 1'b1) begin
               d.st    = eeac_pkg::ST_IDLE;
               d.ready = 1'b1;
               d.command_complete_flag  = 1'b1;
            end else begin
               d.idx = q.idx + 1'b1;
            end
         end
         eeac_pkg::ST_IDLE: begin
            if (i_mass_erase) begin
               nv.erase_all = 1'b1;
               d.ready      = 1'b0;
               d.command_complete_flag       = 1'b0;
               d.enabled    = 1'b0;
               d.st         = eeac_pkg::ST_CFG;
            end else if (i_part_req) begin
               nv.cfg_wr = 1'b1;
               d.command_complete_flag    = 1'b0;
               d.st      = eeac_pkg::ST_PART;
            end else if (i_bus_req && in_win) begin
               if (!in_range) begin
                  d.err = 1'b1;
               end else if (i_bus_we) begin
                  bus_wr = 1'b1;
                  d.ack  = 1'b1;
                  if (q.enabled) begin
                     d.wbase  = wbase;
                     d.hwmask = {|be[3:2], |be[1:0]};
                     d.slot   = ~(|be[1:0]);
                     d.ready  = 1'b0;
                     d.command_complete_flag   = 1'b0;
                     d.st     = eeac_pkg::ST_PGM;
                  end
               end else begin
                  d.ack   = 1'b1;
                  d.rdata = {ram[wbase + AW'(1)], ram[wbase]};
               end
            end
         end
         eeac_pkg::ST_PGM: begin
            nv.raddr = q.wbase + AW'(q.slot);
            nv.wr_en = 1'b1;
            // Erased slot skips the erase phase
            if (!nv.rvalid || nv.rdata == eeac_pkg::ERASED_HW) begin
               d.timer = TW'(PROG_CYCLES - 1);
            end else begin
               d.timer = TW'(ERPG_CYCLES - 1);
            end
            d.st = eeac_pkg::ST_WAIT;
         end
         eeac_pkg::ST_WAIT: begin
            if (q.timer == '0) begin
               nv.commit_en = 1'b1;
               if (!q.slot && q.hwmask[1]) begin
                  d.slot = 1'b1;
                  d.st   = eeac_pkg::ST_PGM;
               end else begin
                  d.st    = eeac_pkg::ST_IDLE;
                  d.ready = 1'b1;
                  d.command_complete_flag  = 1'b1;
               end
            end else begin
               d.timer = q.timer - 1'b1;
            end
         end
         eeac_pkg::ST_PART: begin
            d.command_complete_flag = 1'b1;
            d.st   = eeac_pkg::ST_IDLE;
         end
         default: begin
            d.st = eeac_pkg::ST_CFG;
         end
      endcase
   end

   // Control state; config is fetched fresh after every reset
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         q       <= '0;
         q.st    <= eeac_pkg::ST_CFG;
      end else begin
         q <= d;
      end
   end

   // Emulation RAM image; bus writes land at once, boot fills by index
   always_ff @(posedge i_clk_sys) begin
      if (load_we) begin
         ram[q.idx] <= load_data;
      end else if (bus_wr) begin
         for (int k = 0; k < 2; k++) begin
            for (int b = 0; b < 2; b++) begin
               if (be[2*k+b]) begin
                  ram[wbase + AW'(k)][8*b +: 8] <=
                     i_bus_wdata[16*k + 8*b +: 8];
               end
            end
         end
      end
   end

   // Outputs
   assign o_bus_ack               = q.ack;
   assign o_bus_err               = q.err;
   assign o_bus_rdata             = q.rdata;
   assign o_emulation_ready_flag  = q.ready;
   assign o_command_complete_flag = q.command_complete_flag;
   assign o_cc_irq                = q.command_complete_flag && i_cc_irq_en;
   assign o_emu_enabled           = q.enabled;
   assign o_compromised           = q.compromised;
   assign o_cfg                   = q.cfg;
endmodule
`default_nettype wire

// file: eeac_top_props.sv
// Port-level checker for the emulated EEPROM controller.
// Assumes it is bound into eeac_top and shares its single clock.
`timescale 1ns/1ps
`default_nettype none
module eeac_top_props #(
   parameter int DEPTH       = 2048,
   parameter int ERPG_CYCLES = 15000
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rstn,
   input  wire logic        i_bus_req,
   input  wire logic        i_bus_we,
   input  wire logic [31:0] i_bus_addr,
   input  wire logic        i_part_req,
   input  wire logic        i_mass_erase,
   input  wire logic        i_cc_irq_en,
   input  wire logic        o_bus_ack,
   input  wire logic        o_bus_err,
   input  wire logic        o_pf_sel,
   input  wire logic        o_emulation_ready_flag,
   input  wire logic        o_command_complete_flag,
   input  wire logic        o_cc_irq,
   input  wire logic        o_emu_enabled,
   input  wire logic [11:0] o_cfg
);
   // A word write may need two erase phases back to back
   localparam int MAXW = 2 * ERPG_CYCLES + 8;
   logic        inwin;
   logic        idle;
   logic        insz;
   logic [31:0] off;
   // Request classes; erase and partition win over the bus
   assign off   = i_bus_addr - 32'h1400_0000;
   assign inwin = i_bus_req && !i_mass_erase && !i_part_req
                  && i_bus_addr >= 32'h1400_0000
                  && i_bus_addr <= 32'h17FF_FFFF;
   assign idle  = o_emu_enabled && o_emulation_ready_flag
                  && o_command_complete_flag;
   assign insz  = off < (32'h0000_0020 << o_cfg[11:8]);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   a_no_dual_answer: assert property (!(o_bus_ack && o_bus_err))
      else $error("ack and err together");
   a_oos_error: assert property (inwin && idle && !insz |=> o_bus_err)
      else $error("no error beyond size");
   a_inwin_ack: assert property (inwin && idle && insz |=> o_bus_ack)
      else $error("no ack inside size");
   a_write_starts: assert property (inwin && idle && insz && i_bus_we
      |=> !o_emulation_ready_flag && !o_command_complete_flag)
      else $error("write left flags set");
   a_read_no_flash: assert property (inwin && idle && insz && !i_bus_we
      |=> o_emulation_ready_flag && o_command_complete_flag)
      else $error("read started flash work");
   a_write_bound: assert property (o_bus_ack
      && $fell(o_emulation_ready_flag) |-> ##[1:MAXW] o_emulation_ready_flag)
      else $error("write too slow");
   a_ready_with_cc: assert property ($rose(o_emulation_ready_flag)
      |-> o_command_complete_flag)
      else $error("ready without complete");
   a_irq_gate: assert property (o_cc_irq == (o_command_complete_flag
      && i_cc_irq_en))
      else $error("irq not gated complete");
   a_pf_select: assert property (o_pf_sel == (i_bus_req
      && i_bus_addr <= 32'h0FFF_FFFF))
      else $error("pflash select wrong");
   a_erase_clears: assert property (i_mass_erase && o_command_complete_flag
      |=> !o_emulation_ready_flag && !o_command_complete_flag
      ##[1:3] o_command_complete_flag)
      else $error("mass erase sequence wrong");
   a_part_pulse: assert property (i_part_req && !i_mass_erase
      && o_command_complete_flag |=> !o_command_complete_flag
      ##[1:2] o_command_complete_flag)
      else $error("partition flag pulse wrong");
   a_disabled_ack: assert property (inwin && !o_emu_enabled && i_bus_we
      && o_command_complete_flag && off < 32'(2 * DEPTH)
      |=> o_bus_ack && o_command_complete_flag)
      else $error("disabled write misbehaved");
   c_write: cover property (inwin && idle && i_bus_we);
   c_oos: cover property (inwin && idle && !insz);
   c_ready: cover property ($rose(o_emulation_ready_flag));
endmodule
bind eeac_top eeac_top_props #(
   .DEPTH(DEPTH),
   .ERPG_CYCLES(ERPG_CYCLES)
) u_eeac_top_props (
   .i_clk_sys, .i_rstn, .i_bus_req, .i_bus_we, .i_bus_addr, .i_part_req,
   .i_mass_erase, .i_cc_irq_en, .o_bus_ack, .o_bus_err, .o_pf_sel,
   .o_emulation_ready_flag, .o_command_complete_flag, .o_cc_irq,
   .o_emu_enabled, .o_cfg
);
`default_nettype wire

// file: eeac_host.sv
// Bus master model issuing one-cycle requests to the controller.
// Assumes it is the only master and runs on the system clock.
`timescale 1ns/1ps
`default_nettype none
module eeac_host (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rdy,
   input  wire logic        i_ccf,
   input  wire logic        i_en,
   input  wire logic        i_ack,
   input  wire logic        i_err,
   input  wire logic [31:0] i_rdata,
   output logic             o_req,
   output logic             o_we,
   output logic [1:0]       o_size,
   output logic [31:0]      o_addr,
   output logic [31:0]      o_wdata
);
   // Quiet bus at time zero
   initial begin
      o_req   = 1'b0;
      o_we    = 1'b0;
      o_size  = 2'h0;
      o_addr  = 32'h0000_0000;
      o_wdata = 32'h0000_0000;
   end
   // One access; wt makes it poll for an idle device first
   task automatic acc(input logic we, input logic [1:0] sz,
                      input logic [31:0] a, input logic [31:0] d,
                      input bit wt, output logic ack, output logic err,
                      output logic [31:0] rd);
      int n;
      n = 0;
      // Ready when enabled, else command complete
      while (wt && !(i_en ? i_rdy : i_ccf) && n < 5000) begin
         @(posedge i_clk_sys);
         n++;
      end
      @(posedge i_clk_sys);
      o_req   <= 1'b1;
      o_we    <= we;
      o_size  <= sz;
      o_addr  <= a;
      o_wdata <= d;
      @(posedge i_clk_sys);
      // Released address and data lines flip so a stale value never matches
      o_req   <= 1'b0;
      o_addr  <= ~a;
      o_wdata <= ~d;
      #1;
      ack = i_ack;
      err = i_err;
      rd  = i_rdata;
   endtask
endmodule
`default_nettype wire

// file: test_eeac_top.sv
// Self-checking bench for the emulated EEPROM controller.
// Assumes eeac_host drives the bus; flash times shortened by parameter.
`timescale 1ns/1ps
`default_nettype none
module test_eeac_top;
   localparam int          ERPG = 20;
   localparam int          PROG = 4;
   localparam logic [31:0] WB   = eeac_pkg::WIN_BASE;
   logic        clk;
   logic        rstn;
   logic        preq;
   logic        merase;
   logic        irqen;
   logic [3:0]  psz;
   logic [3:0]  psp;
   logic [3:0]  pfl;
   logic        req, we, ack, err, pf, rdy, ccf, irq, en, comp, a_ok, e_ok;
   logic [1:0]  sz;
   logic [31:0] addr, wdata, rdata, rd;
   logic [11:0] cfg;
   int          n;
   int          error_cnt = 0;
   int          checks = 0;
   int          cyc = 0;
   eeac_top #(.ERPG_CYCLES(ERPG), .PROG_CYCLES(PROG)) u_eeac_top (
      .i_clk_sys(clk), .i_rstn(rstn), .i_bus_req(req), .i_bus_we(we),
      .i_bus_size(sz), .i_bus_addr(addr), .i_bus_wdata(wdata),
      .o_bus_ack(ack), .o_bus_err(err), .o_bus_rdata(rdata),
      .o_pf_sel(pf), .i_part_req(preq), .i_part_size(psz),
      .i_part_split(psp), .i_part_flash(pfl), .i_mass_erase(merase),
      .i_cc_irq_en(irqen), .o_emulation_ready_flag(rdy),
      .o_command_complete_flag(ccf), .o_cc_irq(irq),
      .o_emu_enabled(en), .o_compromised(comp), .o_cfg(cfg));
   eeac_host u_eeac_host (
      .i_clk_sys(clk), .i_rdy(rdy), .i_ccf(ccf), .i_en(en), .i_ack(ack),
      .i_err(err), .i_rdata(rdata), .o_req(req), .o_we(we), .o_size(sz),
      .o_addr(addr), .o_wdata(wdata));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_val(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_rng(input string nm, input int lo, input int hi,
                          input int g);
      checks++;
      if (g < lo || g > hi) begin
         error_cnt++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask
   task automatic do_reset();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
   endtask
   // Bounded waits; the count is the elapsed time in cycles
   // A wait that runs out is counted as a mismatch
   task automatic wait_rdy();
      for (n = 0; rdy !== 1'b1 && n < 3000; n++) @(posedge clk);
      chk_bit("ready wait", 1'b1, rdy);
   endtask
   task automatic wait_cc();
      for (n = 0; ccf !== 1'b1 && n < 3000; n++) @(posedge clk);
      chk_bit("cc wait", 1'b1, ccf);
   endtask
   task automatic wr(input logic [1:0] s, input logic [31:0] a,
                     input logic [31:0] d);
      u_eeac_host.acc(1'b1, s, a, d, 1'b1, a_ok, e_ok, rd);
   endtask
   task automatic rdx(input logic [1:0] s, input logic [31:0] a);
      u_eeac_host.acc(1'b0, s, a, 32'h0000_0000, 1'b1, a_ok, e_ok, rd);
   endtask
   // Mass erase, then a disabled write, then a reboot still disabled
   task automatic t_erase();
      do_reset();
      wait_cc();
      chk_bit("no torn", 1'b0, comp);
      @(posedge clk) merase <= 1'b1;
      @(posedge clk) merase <= 1'b0;
      #1 chk_bit("erase ready", 1'b0, rdy);
      chk_bit("erase cc", 1'b0, ccf);
      wr(eeac_pkg::SZ_HALF, WB, 32'h0000_1234);
      chk_bit("disabled ack", 1'b1, a_ok);
      chk_bit("disabled cc", 1'b1, ccf);
      do_reset();
      wait_cc();
      chk_bit("erased enable", 1'b0, en);
      $display("test erase done");
   endtask
   task automatic t_part();
      @(posedge clk);
      preq <= 1'b1;
      psp  <= 4'h3;
      pfl  <= 4'h5;
      @(posedge clk);
      preq <= 1'b0;
      psp  <= 4'h0;
      pfl  <= 4'h0;
      #1 chk_bit("part cc", 1'b0, ccf);
      do_reset();
      wait_rdy();
      chk_rng("load cycles", 16, 20, n);
      chk_val("cfg", 32'h0000_0035, {20'h0_0000, cfg});
      chk_bit("enabled", 1'b1, en);
      $display("test partition done");
   endtask
   task automatic t_write();
      rdx(eeac_pkg::SZ_WORD, WB);
      chk_val("erased word", 32'hFFFF_FFFF, rd);
      wr(eeac_pkg::SZ_BYTE, WB + 32'h1, 32'h0000_5A00);
      chk_bit("busy cc", 1'b0, ccf);
      wait_rdy();
      chk_rng("byte prog", PROG + 1, PROG + 4, n);
      rdx(eeac_pkg::SZ_BYTE, WB + 32'h1);
      chk_val("byte read", 32'hFFFF_5AFF, rd);
      chk_bit("read cc", 1'b1, ccf);
      wr(eeac_pkg::SZ_HALF, WB, 32'h0000_1234);
      wait_rdy();
      chk_rng("erase prog", ERPG + 1, ERPG + 4, n);
      wr(eeac_pkg::SZ_WORD, WB + 32'h4, 32'hCAFE_BEEF);
      wait_rdy();
      chk_rng("word prog", 2 * PROG + 1, 2 * PROG + 8, n);
      rdx(eeac_pkg::SZ_HALF, WB + 32'h1E);
      chk_bit("last ack", 1'b1, a_ok);
      rdx(eeac_pkg::SZ_BYTE, WB + 32'h20);
      chk_bit("size err", 1'b1, e_ok);
      wr(eeac_pkg::SZ_WORD, 32'h17FF_FFFC, 32'h0000_0000);
      chk_bit("top err", 1'b1, e_ok);
      chk_bit("top no flash", 1'b1, rdy);
      $display("test write done");
   endtask
   task automatic t_busy();
      irqen <= 1'b1;
      wr(eeac_pkg::SZ_HALF, WB, 32'h0000_FFFF);
      chk_bit("irq busy", 1'b0, irq);
      u_eeac_host.acc(1'b0, eeac_pkg::SZ_WORD, WB, 32'h0, 1'b0,
                      a_ok, e_ok, rd);
      chk_bit("busy err", 1'b1, e_ok);
      u_eeac_host.acc(1'b0, eeac_pkg::SZ_WORD, 32'h0000_1000, 32'h0, 1'b0,
                      a_ok, e_ok, rd);
      chk_bit("pflash err", 1'b0, e_ok);
      wait_rdy();
      chk_rng("ff erase", ERPG - 3, ERPG + 4, n);
      chk_bit("irq idle", 1'b1, irq);
      irqen <= 1'b0;
      wr(eeac_pkg::SZ_HALF, WB, 32'h0000_0042);
      wait_rdy();
      chk_rng("pre-erased", PROG + 1, PROG + 4, n);
      chk_bit("irq masked", 1'b0, irq);
      $display("test busy done");
   endtask
   task automatic t_torn();
      do_reset();
      wait_rdy();
      rdx(eeac_pkg::SZ_WORD, WB);
      chk_val("reload", 32'hFFFF_0042, rd);
      wr(eeac_pkg::SZ_HALF, WB + 32'h4, 32'h0000_9999);
      repeat (3) @(posedge clk);
      do_reset();
      wait_rdy();
      chk_bit("torn flag", 1'b1, comp);
      rdx(eeac_pkg::SZ_WORD, WB + 32'h4);
      chk_val("last good", 32'hCAFE_BEEF, rd);
      wr(eeac_pkg::SZ_HALF, WB + 32'h4, 32'h0000_1111);
      rdx(eeac_pkg::SZ_WORD, WB + 32'h4);
      chk_val("replaced", 32'hCAFE_1111, rd);
      $display("test torn done");
   endtask
   // Clock and cycle ceiling
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         $display("MISMATCH timeout expected %0d seen %0d", 20000, cyc);
         print_verdict();
      end
   end
   initial begin
      rstn   = 1'b0;
      preq   = 1'b0;
      merase = 1'b0;
      irqen  = 1'b0;
      psz    = 4'h0;
      psp    = 4'h0;
      pfl    = 4'h0;
      t_erase();
      t_part();
      t_write();
      t_busy();
      t_torn();
      t_erase();
      print_verdict();
   end
endmodule
`default_nettype wire
